// ==== inc/flash_seq_pkg.sv ====
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // Flash geometry
  // ----------------------------------------------------------------
  localparam int          MACRO_BYTES  = 16384;
  localparam int          ADDR_W       = 14;
  localparam int          SECTOR_BYTES = 128;
  localparam int          SECTOR_COUNT = 128;
  localparam int          SECTOR_LSB   = 7;
  localparam logic [13:0] MACRO_LAST   = 14'h3fff;
  localparam logic [13:0] SECTOR_SPAN  = 14'h007f;
  localparam logic [7:0]  CELL_PROGRAMMED = 8'hff;
  localparam logic [7:0]  CELL_ERASED     = 8'h00;
  localparam logic [7:0]  NEUTRAL_BYTE    = 8'h00;

  // ----------------------------------------------------------------
  // Operation field and timed access
  // ----------------------------------------------------------------
  localparam int         OP_W          = 6;
  localparam logic [5:0] OP_NOP        = 6'h00;
  localparam logic [5:0] OP_PROG       = 6'h01;
  localparam logic [5:0] OP_SECT_ERASE = 6'h02;
  localparam logic [5:0] OP_CHIP_ERASE = 6'h04;
  localparam logic [5:0] OP_RESET      = OP_NOP;
  localparam logic [7:0] KEY_FIRST     = 8'haa;
  localparam logic [7:0] KEY_SECOND    = 8'h55;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS     = 25;
  localparam int         WORD_PROG_TIME_NS = 100;
  localparam int         WORD_PROG_CYCLES  = (WORD_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WORD_PROG_LAST    = 8'(WORD_PROG_CYCLES - 1);

  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFS  = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] PWE_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] DATA_OFS = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CMD_KEY,
    CMD_CTRL,
    CMD_DBG,
    CMD_PROG
  } cmd_kind_t;

endpackage : flash_seq_pkg

// ==== inc/flash_seq_if.sv ====
`timescale 1ns/1ps
interface flash_seq_if (
  input wire logic aclk
);
  logic        key_wr;
  logic        ctrl_wr;
  logic        dbg_wr;
  logic [7:0]  sfr_wdata;
  logic        program_write_enable;
  logic        external_move_write;
  logic [15:0] prog_addr;
  logic [7:0]  prog_wdata;
  logic [13:0] rd_addr;
  logic        flash_busy_halt;
  logic [5:0]  op_field;
  logic        unlocked;
  logic [7:0]  rd_data;

  modport device (
    input  key_wr, ctrl_wr, dbg_wr, sfr_wdata, program_write_enable,
    input  external_move_write, prog_addr, prog_wdata, rd_addr,
    output flash_busy_halt, op_field, unlocked, rd_data
  );

  modport host (
    output key_wr, ctrl_wr, dbg_wr, sfr_wdata, program_write_enable,
    output external_move_write, prog_addr, prog_wdata, rd_addr,
    input  flash_busy_halt, op_field, unlocked, rd_data
  );
endinterface : flash_seq_if

// ==== src/flash_seq_device.sv ====
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Operation field 0x04 arms chip erase.
// - Armed chip erase: program write erases macro.
// - Busy held during chip erase.
// - Erase done: drop busy, load no-op code.
// - Whole macro preprogrammed before chip erase.
// - Each further macro needs full procedure again.
// - Macro has 128 sectors of 128 bytes.
// - Field 0x02 with enable arms sector erase.
// - Busy held during sector erase.
// - Sector done: drop busy, load no-op code.
// - Sector preprogrammed before its erase.
// - Field 0x01 with enable arms programming.
// - Odd-address write starts word program, busy.
// - Word programmed: busy drops, core resumes.
// - After word, program next or write zero.
// - Even byte first, odd byte launches write.
// - Neutral byte 0x00 leaves flash bits unchanged.
// - Core control writes need 0xAA, 0x55 key.
// - Enable routes external writes to program space.
module flash_seq_device
  import flash_seq_pkg::*;
(
  input wire logic     aclk,
  input wire logic     aresetn,
  input wire logic     ce,
  flash_seq_if.device  link
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_PREPROG,
    S_ERASE,
    S_PROG_WAIT,
    S_PROG_EVEN,
    S_PROG_ODD
  } seq_state_t;

  typedef enum logic [1:0] {
    K_LOCKED,
    K_FIRST,
    K_OPEN
  } key_state_t;

  seq_state_t  state_r;
  key_state_t  key_r;
  logic [5:0]  op_r;
  logic [13:0] walk_idx_r;
  logic [13:0] walk_end_r;
  logic [13:0] word_addr_r;
  logic [7:0]  even_byte_r;
  logic [7:0]  odd_byte_r;
  logic [7:0]  wait_cnt_r;
  logic [7:0]  rd_data_r;
  logic [7:0]  mem [MACRO_BYTES];

  logic        in_macro;
  logic        start_wr;
  logic        ctrl_take;
  logic [5:0]  ctrl_val;
  logic        walk_last;
  logic        mem_we;
  logic [13:0] mem_wa;
  logic [7:0]  mem_wd;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Only one macro exists; writes that select another macro fall outside it.
  assign in_macro  = (link.prog_addr[15:14] == 2'b00);
  assign start_wr  = link.external_move_write && link.program_write_enable && in_macro
                     && (state_r == S_IDLE);
  assign walk_last = (walk_idx_r == walk_end_r);

  // Writes are ignored while busy, since the halted core cannot issue them.
  assign ctrl_take = (state_r == S_IDLE)
                     && ((link.ctrl_wr && key_r == K_OPEN) || link.dbg_wr);

  always_comb begin
    ctrl_val = link.sfr_wdata[5:0];
    // Both erase bits at once is meaningless; those two bits keep their value.
    if (ctrl_val[2:1] == 2'b11) begin
      ctrl_val[2:1] = op_r[2:1];
    end
  end

  // ----------------------------------------------------------------
  // Timed access key
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_r <= K_LOCKED;
    end else if (ce) begin
      if (link.key_wr) begin
        if (link.sfr_wdata == KEY_FIRST) begin
          key_r <= K_FIRST;
        end else if (link.sfr_wdata == KEY_SECOND && key_r == K_FIRST) begin
          key_r <= K_OPEN;
        end else begin
          key_r <= K_LOCKED;
        end
      end else if (link.ctrl_wr) begin
        key_r <= K_LOCKED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operation field
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_r <= OP_RESET;
    end else if (ce) begin
      if ((state_r == S_ERASE) && walk_last) begin
        op_r <= OP_NOP;
      end else if (ctrl_take) begin
        op_r <= ctrl_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= S_IDLE;
      walk_idx_r  <= 14'h0000;
      walk_end_r  <= 14'h0000;
      word_addr_r <= 14'h0000;
      odd_byte_r  <= NEUTRAL_BYTE;
      wait_cnt_r  <= 8'h00;
    end else if (ce) begin
      case (state_r)
        S_IDLE: begin
          if (start_wr) begin
            case (op_r)
              OP_CHIP_ERASE: begin
                walk_idx_r <= 14'h0000;
                walk_end_r <= MACRO_LAST;
                state_r    <= S_PREPROG;
              end
              OP_SECT_ERASE: begin
                walk_idx_r <= {link.prog_addr[13:SECTOR_LSB], 7'h00};
                walk_end_r <= {link.prog_addr[13:SECTOR_LSB], 7'h00} + SECTOR_SPAN;
                state_r    <= S_PREPROG;
              end
              OP_PROG: begin
                if (link.prog_addr[0]) begin
                  word_addr_r <= {link.prog_addr[13:1], 1'b0};
                  odd_byte_r  <= link.prog_wdata;
                  wait_cnt_r  <= 8'h00;
                  state_r     <= S_PROG_WAIT;
                end
              end
              default: begin
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        S_PREPROG: begin
          if (walk_last) begin
            walk_idx_r <= (walk_end_r == MACRO_LAST) ? 14'h0000 : (walk_end_r - SECTOR_SPAN);
            state_r    <= S_ERASE;
          end else begin
            walk_idx_r <= walk_idx_r + 14'h0001;
          end
        end
        S_ERASE: begin
          if (walk_last) begin
            state_r <= S_IDLE;
          end else begin
            walk_idx_r <= walk_idx_r + 14'h0001;
          end
        end
        S_PROG_WAIT: begin
          if (wait_cnt_r == WORD_PROG_LAST) begin
            state_r <= S_PROG_EVEN;
          end else begin
            wait_cnt_r <= wait_cnt_r + 8'h01;
          end
        end
        S_PROG_EVEN: begin
          state_r <= S_PROG_ODD;
        end
        S_PROG_ODD: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Even byte holding register
  // ----------------------------------------------------------------
  // An odd write with no even partner programs the neutral byte in its place.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      even_byte_r <= NEUTRAL_BYTE;
    end else if (ce) begin
      if (start_wr && op_r == OP_PROG && !link.prog_addr[0]) begin
        even_byte_r <= link.prog_wdata;
      end else if (state_r == S_PROG_ODD) begin
        even_byte_r <= NEUTRAL_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash array
  // ----------------------------------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_wa = walk_idx_r;
    mem_wd = CELL_ERASED;
    case (state_r)
      S_PREPROG: begin
        mem_we = 1'b1;
        mem_wd = CELL_PROGRAMMED;
      end
      S_ERASE: begin
        mem_we = 1'b1;
        mem_wd = CELL_ERASED;
      end
      S_PROG_EVEN: begin
        mem_we = 1'b1;
        mem_wa = word_addr_r;
        mem_wd = mem[word_addr_r] | even_byte_r;
      end
      S_PROG_ODD: begin
        mem_we = 1'b1;
        mem_wa = word_addr_r | 14'h0001;
        mem_wd = mem[word_addr_r | 14'h0001] | odd_byte_r;
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  // The array has no reset; its content is undefined until first erased.
  always_ff @(posedge aclk) begin
    if (ce && aresetn && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_r <= 8'h00;
    end else if (ce) begin
      rd_data_r <= mem[link.rd_addr];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.flash_busy_halt = (state_r != S_IDLE);
  assign link.op_field        = op_r;
  assign link.unlocked        = (key_r == K_OPEN);
  assign link.rd_data         = rd_data_r;

endmodule : flash_seq_device

// ==== src/flash_seq_host.sv ====
`timescale 1ns/1ps
module flash_seq_host
  import flash_seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  flash_seq_if.host        link
);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_r;
  logic        aw_got_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_got_r;
  logic [13:0] addr_r;
  logic        pwe_r;
  logic        pend_r;
  cmd_kind_t   kind_r;
  logic [7:0]  cmd_data_r;
  logic        issue_r;
  logic        do_wr;
  logic        issue;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign do_wr         = aw_got_r && w_got_r && !s_axi_bvalid;
  // Commands wait while the core is halted by the sequencer.
  assign issue         = pend_r && !link.flash_busy_halt && !issue_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == CMD_OFS || awaddr_r == ADDR_OFS || awaddr_r == PWE_OFS)
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r     <= 14'h0000;
      pwe_r      <= 1'b0;
      pend_r     <= 1'b0;
      kind_r     <= CMD_KEY;
      cmd_data_r <= 8'h00;
      issue_r    <= 1'b0;
    end else if (ce) begin
      issue_r <= issue;
      if (issue) begin
        pend_r <= 1'b0;
      end else if (do_wr && awaddr_r == CMD_OFS && wstrb_r[0] && !pend_r) begin
        pend_r     <= 1'b1;
        cmd_data_r <= wdata_r[7:0];
        kind_r     <= cmd_kind_t'(wdata_r[9:8]);
      end
      if (do_wr && awaddr_r == ADDR_OFS && wstrb_r[0]) begin
        addr_r[7:0] <= wdata_r[7:0];
      end
      if (do_wr && awaddr_r == ADDR_OFS && wstrb_r[1]) begin
        addr_r[13:8] <= wdata_r[13:8];
      end
      if (do_wr && awaddr_r == PWE_OFS && wstrb_r[0]) begin
        pwe_r <= wdata_r[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          CMD_OFS:  s_axi_rdata <= {22'h0, kind_r, cmd_data_r};
          ADDR_OFS: s_axi_rdata <= {18'h0, addr_r};
          PWE_OFS:  s_axi_rdata <= {31'h0, pwe_r};
          STAT_OFS: s_axi_rdata <= {18'h0, link.op_field, 5'h0, link.unlocked, pend_r,
                                    link.flash_busy_halt | issue_r};
          DATA_OFS: s_axi_rdata <= {24'h0, link.rd_data};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------
  assign link.key_wr               = issue && kind_r == CMD_KEY;
  assign link.ctrl_wr              = issue && kind_r == CMD_CTRL;
  assign link.dbg_wr               = issue && kind_r == CMD_DBG;
  assign link.external_move_write  = issue && kind_r == CMD_PROG;
  assign link.sfr_wdata            = cmd_data_r;
  assign link.prog_wdata           = cmd_data_r;
  assign link.prog_addr            = {2'b00, addr_r};
  assign link.program_write_enable = pwe_r;
  assign link.rd_addr              = addr_r;

endmodule : flash_seq_host

// ==== sim/flash_seq_checker.sv ====
`timescale 1ns/1ps
module flash_seq_checker
  import flash_seq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        ctrl_wr,
  input wire logic        dbg_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        program_write_enable,
  input wire logic        external_move_write,
  input wire logic [15:0] prog_addr,
  input wire logic        flash_busy_halt,
  input wire logic [5:0]  op_field,
  input wire logic        unlocked
);
  // ----------------------------------------------------------------
  // Busy span counter
  // ----------------------------------------------------------------
  logic [16:0] cnt_r;
  logic [5:0]  op0_r;
  logic        go;
  assign go = external_move_write && ce && !flash_busy_halt && program_write_enable && prog_addr[15:14] == 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn || !flash_busy_halt) cnt_r <= '0;
    else if (ce) cnt_r <= cnt_r + 17'h00001;
  end
  // The op seen just before busy rose tells which operation the span belongs to.
  always_ff @(posedge aclk) begin
    if (!flash_busy_halt) op0_r <= op_field;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_erase_start: assert property (go && (op_field == OP_CHIP_ERASE || op_field == OP_SECT_ERASE) |=> flash_busy_halt)
    else $error("erase did not start");
  a_odd_start: assert property (go && op_field == OP_PROG && prog_addr[0] |=> flash_busy_halt)
    else $error("word program did not start");
  a_even_idle: assert property (go && op_field == OP_PROG && !prog_addr[0] |=> !flash_busy_halt)
    else $error("even byte started a cycle");
  a_no_start: assert property (external_move_write && !flash_busy_halt
                               && (!program_write_enable || op_field == OP_NOP) |=> !flash_busy_halt)
    else $error("write started an operation");
  a_chip_span: assert property ($fell(flash_busy_halt) && op0_r == OP_CHIP_ERASE |-> cnt_r == 17'h08000)
    else $error("chip erase busy span wrong");
  a_sect_span: assert property ($fell(flash_busy_halt) && op0_r == OP_SECT_ERASE |-> cnt_r == 17'h00100)
    else $error("sector erase busy span wrong");
  a_word_span: assert property ($fell(flash_busy_halt) && op0_r == OP_PROG
                                |-> cnt_r == 17'(WORD_PROG_CYCLES + 2) && op_field == OP_PROG)
    else $error("word program span or op wrong");
  a_nop_load: assert property ($fell(flash_busy_halt) && op0_r != OP_PROG |-> op_field == OP_NOP)
    else $error("no-op code not loaded");
  a_busy_hold: assert property (flash_busy_halt && $past(flash_busy_halt) |-> $stable(op_field))
    else $error("op changed while busy");
  a_lock_ctrl: assert property (ctrl_wr && ce && !unlocked && !flash_busy_halt |=> $stable(op_field))
    else $error("locked write changed op");
  a_dbg_write: assert property (dbg_wr && ce && !flash_busy_halt && sfr_wdata[2:1] != 2'b11
                                |=> op_field == $past(sfr_wdata[5:0]))
    else $error("debug write not applied");
  c_chip: cover property ($fell(flash_busy_halt) && op0_r == OP_CHIP_ERASE);
  c_sect: cover property ($fell(flash_busy_halt) && op0_r == OP_SECT_ERASE);
  c_word: cover property ($fell(flash_busy_halt) && op0_r == OP_PROG);
endmodule : flash_seq_checker

// ==== sim/flash_erase_program_sequencer_bench.sv ====
`timescale 1ns/1ps
module flash_erase_program_sequencer_bench
  import flash_seq_pkg::*;
;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d0, d1;
  logic [31:0] s_axi_wdata, s_axi_rdata, rs, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [1:0]  bq[$];
  logic [65:0] rq[$];
  logic [65:0] re;
  logic [13:0] a;
  int          fail_count, checked;
  flash_seq_if      link (.aclk(aclk));
  flash_seq_device  i_flash_seq_device (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(link));
  flash_seq_host    i_flash_seq_host (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(link),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  flash_seq_checker i_flash_seq_checker (.aclk(aclk), .aresetn(aresetn), .ce(ce), .ctrl_wr(link.ctrl_wr),
    .dbg_wr(link.dbg_wr), .sfr_wdata(link.sfr_wdata), .program_write_enable(link.program_write_enable),
    .external_move_write(link.external_move_write), .prog_addr(link.prog_addr),
    .flash_busy_halt(link.flash_busy_halt), .op_field(link.op_field), .unlocked(link.unlocked));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Handshakes are judged at the falling edge, where they equal what the next rising edge samples.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    bq.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er = RESP_OKAY);
    logic ta, tr;
    rq.push_back({er, e & m, m});
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask : rd
  task automatic cmd(input logic [1:0] k, input logic [7:0] d);
    int n;
    wr(CMD_OFS, {22'h0, k, d}, RESP_OKAY);
    n = 0;
    do begin
      rd(STAT_OFS, 32'h0, 32'h0);
      n++;
    end while (v[1:0] !== 2'b00 && n < 20000);
    chk("cmd done", {30'h0, v[1:0]}, 32'h0);
  endtask : cmd
  task automatic stat(input logic [5:0] op, input logic unl);
    rd(STAT_OFS, {18'h0, op, 5'h0, unl, 2'h0}, 32'h00003f07);
  endtask : stat
  task automatic peek(input logic [13:0] ad, input logic [7:0] e);
    wr(ADDR_OFS, {18'h0, ad}, RESP_OKAY);
    rd(DATA_OFS, {24'h0, e}, 32'h000000ff);
  endtask : peek
  task automatic pb(input logic [13:0] ad, input logic [7:0] d);
    wr(ADDR_OFS, {18'h0, ad}, RESP_OKAY);
    cmd(2'd3, d);
  endtask : pb
  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      chk("rdata", s_axi_rdata & re[31:0], re[63:32]);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, re[65:64]});
    end
  end
  initial begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    ce = 1'b1;
    rs = 32'h00000015;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    stat(OP_NOP, 1'b0);
    wr(8'h20, 32'h0, RESP_SLVERR);
    rd(8'h24, 32'h0, 32'hffffffff, RESP_SLVERR);
    cmd(2'd1, {2'h0, OP_CHIP_ERASE});
    stat(OP_NOP, 1'b0);
    cmd(2'd0, KEY_FIRST);
    cmd(2'd0, KEY_SECOND);
    stat(OP_NOP, 1'b1);
    cmd(2'd1, {2'h0, OP_CHIP_ERASE});
    stat(OP_CHIP_ERASE, 1'b0);
    wr(PWE_OFS, 32'h1, RESP_OKAY);
    pb(14'h1235, xs());
    stat(OP_NOP, 1'b0);
    peek(14'h0000, CELL_ERASED);
    peek(MACRO_LAST, CELL_ERASED);
    $display("Test chip erase done");
    cmd(2'd2, {2'h0, OP_PROG});
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? (14'h0280 | {6'h0, xs() & 8'h3e}) : (i == 1) ? 14'h02fe : 14'h0300;
      d0 = xs();
      d1 = xs();
      pb(a, d0);
      peek(a, CELL_ERASED);
      pb(a | 14'h0001, d1);
      stat(OP_PROG, 1'b0);
      peek(a, d0);
      peek(a | 14'h0001, d1);
    end
    pb(14'h0306, 8'hff);
    pb(14'h0307, NEUTRAL_BYTE);
    peek(14'h0306, 8'hff);
    peek(14'h0307, CELL_ERASED);
    cmd(2'd2, {2'h0, OP_NOP});
    stat(OP_NOP, 1'b0);
    $display("Test word program done");
    cmd(2'd0, KEY_FIRST);
    cmd(2'd0, KEY_SECOND);
    cmd(2'd1, {2'h0, OP_SECT_ERASE});
    pb(14'h02a0, xs());
    stat(OP_NOP, 1'b0);
    peek(a - 14'h0080, CELL_ERASED);
    peek(14'h02ff, CELL_ERASED);
    peek(14'h0300, d0);
    $display("Test sector erase done");
    pb(14'h0401, 8'hff);
    peek(14'h0401, CELL_ERASED);
    cmd(2'd2, {2'h0, OP_PROG});
    wr(PWE_OFS, 32'h0, RESP_OKAY);
    pb(14'h0400, 8'hff);
    pb(14'h0401, 8'hff);
    peek(14'h0400, CELL_ERASED);
    cmd(2'd2, 8'h06);
    stat(OP_NOP, 1'b0);
    cmd(2'd0, KEY_FIRST);
    cmd(2'd0, 8'h12);
    stat(OP_NOP, 1'b0);
    $display("Test refusals done");
    end_sim();
  end
endmodule : flash_erase_program_sequencer_bench
